/* host_model.sv */
`timescale 1ns/1ps
// Host controller: issues command strobes and collects read answers.
module host_model (
  // Clock.
  input  wire logic             clk_i,
  // Read answer from the device.
  input  wire logic [15:0]      rdata_i,
  input  wire logic             rvalid_i,
  // Command strobes to the device.
  output status_pkg::host_cmd_s cmd_o
);
  // The bus starts idle.
  initial cmd_o = '0;
  // One-cycle write strobe: kind 0 event mask, 1 service mask, 2 clear status.
  task automatic put(input int kind, input logic [15:0] d);
    @(posedge clk_i);
    cmd_o.wdata <= d;
    cmd_o.ques_mask_wr <= (kind == 0);
    cmd_o.srm_wr <= (kind == 1);
    cmd_o.clear_status <= (kind == 2);
    @(posedge clk_i);
    cmd_o.ques_mask_wr <= 1'b0;
    cmd_o.srm_wr <= 1'b0;
    cmd_o.clear_status <= 1'b0;
  endtask
  // Read request; ok stays low when no answer comes within four cycles.
  task automatic get(input status_pkg::read_sel_e s, output logic [15:0] d, output bit ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk_i);
    cmd_o.rd_sel <= s;
    cmd_o.rd_req <= 1'b1;
    @(posedge clk_i);
    cmd_o.rd_req <= 1'b0;
    for (int k = 0; k < 4 && !ok; k++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        ok = 1'b1;
      end
    end
  endtask
endmodule

/* instrument_status_summary.sv */
`timescale 1ns/1ps
// Functional notes
// - Questionable bits latch until read or clear.
// - Bits 0,1,9 flag voltage/current/ohms overloads.
// - Bit 11 low limit, bit 12 high.
// - Bit 13 remote; other bits unused zero.
// - Questionable mask gates summary contribution.
// - Enabled rising event sets status bit 3.
// - Event read or clear drops bit 3.
// - Status byte eight bits; 0,1,2,7 zero.
// - Message bit set on response, cleared by terminator.
// - Standard event summary sets bit 5.
// - Master summary is OR of enabled bits.
// - Request flag set by panel/summary; poll clears.
// - Service request line follows request flag.
// - Status byte query changes nothing.
// - Bit 6 is flag on poll, summary on query.
// - Query returns byte as plain binary value.
// - Host loads eight-bit service request mask.
// - Only mask bits 1-5 and 7 count.
// - Master summary rise (first status bit set with its counted mask bit) sets request bit.
// - Mask read shows bit 6 as zero.
module instrument_status_summary #(
  parameter int unsigned QUES_W = 16,  // Questionable register width.
  parameter int unsigned STB_W  = 8    // Status byte width.
) (
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // Measurement conditions.
  input  wire status_pkg::meas_cond_s meas_i,
  // Output buffer and standard event summary.
  input  wire logic                   resp_queued_i,
  input  wire logic                   term_sent_i,
  input  wire logic                   std_event_sum_i,
  // Front panel.
  input  wire logic                   panel_srq_i,
  // Host command strobes.
  input  wire status_pkg::host_cmd_s  cmd_i,
  // Read answer.
  output logic [QUES_W-1:0]           rdata_o,
  output logic                        rvalid_o,
  // Bus service request line and status view.
  output logic                        srq_o,
  output logic [STB_W-1:0]            status_byte_o
);

  logic [QUES_W-1:0] ques_set;        // Set strobes for each questionable bit.
  logic [QUES_W-1:0] questionable_event_latch;  // Latched questionable events.
  logic [QUES_W-1:0] ques_mask_ff;    // Questionable enable mask.
  logic [STB_W-1:0]  srm_ff;          // Service request mask.
  logic              ques_rd;         // Host reads the event register.
  logic              clr;             // Clear-status command.
  logic              poll_rd;         // Serial poll read.
  logic              ques_any;        // Any enabled questionable bit set.
  logic              ques_rise;       // Enabled questionable bits went high.
  logic              ques_sum;        // Questionable summary, status bit 3.
  logic              msg_avail_ff;    // Message available bit.
  logic              standard_event_summary_bit;             // Standard event summary bit.
  logic              master_summary_bit;             // Master summary bit.
  logic              mss_rise;        // Master summary went high.
  logic              request_service_flag;             // Request service flag.
  logic [STB_W-1:0]  stb_base;        // Status byte without bit 6.
  logic [QUES_W-1:0] nxt_rdata;       // Next read answer.

  // Decode of the host strobes.
  assign clr     = cmd_i.clear_status;
  assign ques_rd = cmd_i.rd_req && (cmd_i.rd_sel == status_pkg::RD_QUES_EVENT);
  assign poll_rd = cmd_i.rd_req && (cmd_i.rd_sel == status_pkg::RD_SERIAL_POLL);

  // Map each measurement condition to its questionable bit.
  always_comb begin
    ques_set = '0;
    ques_set[status_pkg::QUES_VOLT_OVLD_BIT] = meas_i.volt_ovld;
    ques_set[status_pkg::QUES_CURR_OVLD_BIT] = meas_i.curr_ovld;
    ques_set[status_pkg::QUES_OHMS_OVLD_BIT] = meas_i.ohms_ovld;
    ques_set[status_pkg::QUES_LIMIT_LO_BIT]  = meas_i.limit_lo;
    ques_set[status_pkg::QUES_LIMIT_HI_BIT]  = meas_i.limit_hi;
    ques_set[status_pkg::QUES_REMOTE_BIT]    = meas_i.remote;
  end

  // One sticky cell per used bit; unused bits stay zero.
  genvar gi;
  generate
    for (gi = 0; gi < QUES_W; gi++) begin : g_ques
      if (status_pkg::QUES_USED_MASK[gi]) begin : g_used
        sticky_bit u_bit (
          .clk_i  (clk_i),
          .rstn_i (rstn_i),
          .set_i  (ques_set[gi]),
          .clr_i  (ques_rd | clr),
          .q_o    (questionable_event_latch[gi])
        );
      end else begin : g_unused
        assign questionable_event_latch[gi] = 1'b0;
      end
    end
  endgenerate

  // Host writes to the questionable mask register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ques_mask_ff <= status_pkg::QUES_MASK_RST;
    end else if (cmd_i.ques_mask_wr) begin
      ques_mask_ff <= cmd_i.wdata[QUES_W-1:0];
    end
  end

  // Service request mask register; all eight bits stored.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srm_ff <= status_pkg::SRM_RST;
    end else if (cmd_i.srm_wr) begin
      srm_ff <= cmd_i.wdata[STB_W-1:0];
    end
  end

  // Summary of enabled questionable events.
  assign ques_any = |(questionable_event_latch & ques_mask_ff);

  // Rising edge of the enabled summary.
  rise_detect u_ques_rise (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .lvl_i  (ques_any),
    .rise_o (ques_rise)
  );

  // Questionable summary bit: set on enabled rise, dropped by read or clear.
  sticky_bit u_ques_sum (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .set_i  (ques_rise),
    .clr_i  (ques_rd | clr),
    .q_o    (ques_sum)
  );

  // Message available follows the output buffer.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msg_avail_ff <= 1'b0;
    end else if (resp_queued_i) begin
      msg_avail_ff <= 1'b1;
    end else if (term_sent_i) begin
      msg_avail_ff <= 1'b0;
    end
  end

  // Standard event summary arrives already masked.
  assign standard_event_summary_bit = std_event_sum_i;

  // Status byte with bit 6 left open; bits 0,1,2,7 tie low.
  always_comb begin
    stb_base = '0;
    stb_base[status_pkg::STB_QUES_BIT] = ques_sum;
    stb_base[status_pkg::STB_MSG_BIT]  = msg_avail_ff;
    stb_base[status_pkg::STB_ESB_BIT]  = standard_event_summary_bit;
  end

  // Master summary over the mask bits allowed to contribute.
  assign master_summary_bit = |(stb_base & srm_ff & status_pkg::SRM_USED_MASK);

  // Master summary rise detector for the request flag.
  rise_detect u_mss_rise (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .lvl_i  (master_summary_bit),
    .rise_o (mss_rise)
  );

  // Request service flag, cleared by a serial poll after it is returned.
  sticky_bit u_rqs (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .set_i  (panel_srq_i | mss_rise),
    .clr_i  (poll_rd),
    .q_o    (request_service_flag)
  );

  // Read answer mux; the current state is returned before any clear.
  always_comb begin
    nxt_rdata = '0;
    case (cmd_i.rd_sel)
      status_pkg::RD_QUES_EVENT: begin
        nxt_rdata = questionable_event_latch;
      end
      status_pkg::RD_QUES_MASK: begin
        nxt_rdata = ques_mask_ff;
      end
      status_pkg::RD_STB_QUERY: begin
        // Query shows the master summary and clears nothing.
        nxt_rdata[STB_W-1:0] = stb_base;
        nxt_rdata[status_pkg::STB_RQS_BIT] = master_summary_bit;
      end
      status_pkg::RD_SERIAL_POLL: begin
        nxt_rdata[STB_W-1:0] = stb_base;
        nxt_rdata[status_pkg::STB_RQS_BIT] = request_service_flag;
      end
      status_pkg::RD_SRM: begin
        nxt_rdata[STB_W-1:0] = srm_ff;
        nxt_rdata[status_pkg::STB_RQS_BIT] = 1'b0;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // Registered read answer, one cycle after the request.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cmd_i.rd_req;
      if (cmd_i.rd_req) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

  // Service request line and live status view, both registered.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srq_o         <= 1'b0;
      status_byte_o <= '0;
    end else begin
      srq_o         <= request_service_flag;
      status_byte_o <= stb_base | ({{(STB_W-1){1'b0}}, master_summary_bit} << status_pkg::STB_RQS_BIT);
    end
  end

endmodule

/* instrument_status_summary_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the status summary block.
module instrument_status_summary_bench;
  logic                   clk_i, rstn_i, resp, term, esum, panel, rvalid, srq;
  status_pkg::meas_cond_s meas;
  status_pkg::host_cmd_s  cmd;
  logic [15:0]            rdata;
  logic [7:0]             stb;
  int                     error_cnt, n_compared;
  // Event bit position for each condition, in struct order.
  int unsigned pos [6] = '{0, 1, 9, 11, 12, 13};
  instrument_status_summary instrument_status_summary_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .meas_i(meas), .resp_queued_i(resp), .term_sent_i(term), .std_event_sum_i(esum),
    .panel_srq_i(panel), .cmd_i(cmd), .rdata_o(rdata), .rvalid_o(rvalid), .srq_o(srq),
    .status_byte_o(stb));
  host_model host_model_i (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_o(cmd));
  // Counts and reports the verdict, then stops.
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compares a value against its expectation.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads through the host and compares; a missing answer ends the run.
  task automatic rd(input status_pkg::read_sel_e s, input logic [15:0] exp);
    logic [15:0] d;
    bit          ok;
    host_model_i.get(s, d, ok);
    if (!ok) begin
      error_cnt++;
      close_out();
    end else begin
      chk(d, exp);
    end
  endtask
  // One-cycle pulse on condition i.
  task automatic hit(input int i);
    @(posedge clk_i);
    meas <= status_pkg::meas_cond_s'(6'h20 >> i);
    @(posedge clk_i);
    meas <= '0;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Free-running clock at 10 MHz.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Main sequence.
  initial begin
    {rstn_i, resp, term, esum, panel} = '0;
    meas = '0;
    error_cnt = 0;
    n_compared = 0;
    w(16);
    rstn_i <= 1'b1;
    w(2);
    chk({8'h00, stb}, 16'h0000);
    host_model_i.put(0, 16'hffff);
    rd(status_pkg::RD_QUES_MASK, 16'hffff);
    host_model_i.put(1, 16'h0008);
    hit(0);
    w(4);
    chk({8'h00, stb}, 16'h0048);
    chk({15'h0, srq}, 16'h0001);
    rd(status_pkg::RD_STB_QUERY, 16'h0048);
    rd(status_pkg::RD_STB_QUERY, 16'h0048);
    rd(status_pkg::RD_SERIAL_POLL, 16'h0048);
    w(3);
    chk({15'h0, srq}, 16'h0000);
    rd(status_pkg::RD_SERIAL_POLL, 16'h0008);
    rd(status_pkg::RD_QUES_EVENT, 16'h0001);
    w(2);
    chk({8'h00, stb}, 16'h0000);
    rd(status_pkg::RD_QUES_EVENT, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      hit(i);
      w(2);
      rd(status_pkg::RD_QUES_EVENT, 16'h0001 << pos[i]);
    end
    host_model_i.put(0, 16'h0001);
    hit(1);
    w(4);
    chk({8'h00, stb}, 16'h0000);
    rd(status_pkg::RD_QUES_EVENT, 16'h0002);
    host_model_i.put(0, 16'hffff);
    hit(2);
    w(4);
    host_model_i.put(2, 16'h0000);
    w(2);
    chk({8'h00, stb}, 16'h0000);
    rd(status_pkg::RD_QUES_EVENT, 16'h0000);
    host_model_i.put(1, 16'h0030);
    resp <= 1'b1;
    esum <= 1'b1;
    w(1);
    resp <= 1'b0;
    w(4);
    chk({8'h00, stb}, 16'h0070);
    term <= 1'b1;
    w(1);
    term <= 1'b0;
    w(4);
    chk({8'h00, stb}, 16'h0060);
    esum <= 1'b0;
    host_model_i.put(1, 16'h00ff);
    rd(status_pkg::RD_SRM, 16'h00bf);
    host_model_i.put(1, 16'h0041);
    esum <= 1'b1;
    w(4);
    chk({8'h00, stb}, 16'h0020);
    esum <= 1'b0;
    w(4);
    rd(status_pkg::RD_SERIAL_POLL, 16'h0040);
    panel <= 1'b1;
    w(1);
    panel <= 1'b0;
    w(3);
    chk({15'h0, srq}, 16'h0001);
    rd(status_pkg::RD_SERIAL_POLL, 16'h0040);
    w(3);
    chk({15'h0, srq}, 16'h0000);
    meas <= status_pkg::meas_cond_s'(6'h20);
    w(2);
    rd(status_pkg::RD_QUES_EVENT, 16'h0001);
    rd(status_pkg::RD_QUES_EVENT, 16'h0001);
    close_out();
  end
endmodule
bind instrument_status_summary status_chk status_chk_i (.clk_i(clk_i), .rstn_i(rstn_i),
  .meas_i(meas_i), .resp_queued_i(resp_queued_i), .term_sent_i(term_sent_i),
  .std_event_sum_i(std_event_sum_i), .panel_srq_i(panel_srq_i), .cmd_i(cmd_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .srq_o(srq_o), .status_byte_o(status_byte_o));

/* rise_detect.sv */
`timescale 1ns/1ps
// Detects a 0-to-1 transition of a level.
module rise_detect (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Level in and pulse out.
  input  wire logic lvl_i,
  output logic      rise_o
);

  logic lvl_ff;  // Previous sample of the level.

  // Samples the level every cycle.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_ff <= 1'b0;
    end else begin
      lvl_ff <= lvl_i;
    end
  end

  // A rise is a high level that was low one cycle ago.
  assign rise_o = lvl_i & ~lvl_ff;

endmodule

/* status_chk.sv */
`timescale 1ns/1ps
// Watches the status block ports and checks timing relations.
module status_chk (
  // Clock and reset.
  input wire logic                   clk_i,
  input wire logic                   rstn_i,
  // Inputs of the block.
  input wire status_pkg::meas_cond_s meas_i,
  input wire logic                   resp_queued_i,
  input wire logic                   term_sent_i,
  input wire logic                   std_event_sum_i,
  input wire logic                   panel_srq_i,
  input wire status_pkg::host_cmd_s  cmd_i,
  // Outputs of the block.
  input wire logic [15:0]            rdata_o,
  input wire logic                   rvalid_o,
  input wire logic                   srq_o,
  input wire logic [7:0]             status_byte_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // High while the host takes a serial poll.
  wire logic poll = cmd_i.rd_req && (cmd_i.rd_sel == status_pkg::RD_SERIAL_POLL);
  property p_zero; status_byte_o[2:0] == 3'h0 && !status_byte_o[7]; endproperty
  a_zero: assert property (p_zero) else $error("fixed status bit set");
  property p_ans; rvalid_o == $past(cmd_i.rd_req); endproperty
  a_ans: assert property (p_ans) else $error("read answer mistimed");
  property p_unused;
    rvalid_o && $past(cmd_i.rd_sel) == status_pkg::RD_QUES_EVENT
      |-> (rdata_o & ~status_pkg::QUES_USED_MASK) == 16'h0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused event bit set");
  property p_srm6;
    rvalid_o && $past(cmd_i.rd_sel) == status_pkg::RD_SRM |-> !rdata_o[6];
  endproperty
  a_srm6: assert property (p_srm6) else $error("mask bit 6 reads one");
  property p_clr;
    (cmd_i.clear_status && meas_i == '0 && $past(meas_i, 1) == '0 && $past(meas_i, 2) == '0
      && $past(meas_i, 3) == '0) ##1 meas_i == '0 |=> !status_byte_o[3];
  endproperty
  a_clr: assert property (p_clr) else $error("summary bit 3 kept");
  property p_mav; resp_queued_i |-> ##[1:2] status_byte_o[4]; endproperty
  a_mav: assert property (p_mav) else $error("message bit not set");
  property p_esb; std_event_sum_i [*3] |-> status_byte_o[5]; endproperty
  a_esb: assert property (p_esb) else $error("event summary not shown");
  property p_panel; (panel_srq_i && !poll) ##1 !poll ##1 !poll |-> srq_o; endproperty
  a_panel: assert property (p_panel) else $error("no service request");
  property p_poll;
    (poll && !panel_srq_i) ##1 (!panel_srq_i && $stable(status_byte_o)) [*2] |=> !srq_o;
  endproperty
  a_poll: assert property (p_poll) else $error("poll left request up");
  // Main scenarios.
  c_poll: cover property (poll);
  c_clear: cover property (cmd_i.clear_status);
  c_panel: cover property (panel_srq_i);
endmodule

/* status_pkg.sv */
package status_pkg;

  // Questionable event bit positions.
  localparam int unsigned QUES_VOLT_OVLD_BIT = 0;
  localparam int unsigned QUES_CURR_OVLD_BIT = 1;
  localparam int unsigned QUES_OHMS_OVLD_BIT = 9;
  localparam int unsigned QUES_LIMIT_LO_BIT  = 11;
  localparam int unsigned QUES_LIMIT_HI_BIT  = 12;
  localparam int unsigned QUES_REMOTE_BIT    = 13;

  // Bits of the questionable register that can ever be set.
  localparam logic [15:0] QUES_USED_MASK = 16'h3a03;

  // Summary status byte bit positions.
  localparam int unsigned STB_QUES_BIT = 3;
  localparam int unsigned STB_MSG_BIT  = 4;
  localparam int unsigned STB_ESB_BIT  = 5;
  localparam int unsigned STB_RQS_BIT  = 6;

  // Service request mask bits that may feed the master summary.
  localparam logic [7:0] SRM_USED_MASK = 8'hbe;

  // Reset values.
  localparam logic [15:0] QUES_LATCH_RST = 16'h0000;
  localparam logic [15:0] QUES_MASK_RST  = 16'h0000;
  localparam logic [7:0]  SRM_RST        = 8'h00;

  // Status read selector.
  typedef enum logic [2:0] {
    RD_QUES_EVENT,
    RD_QUES_MASK,
    RD_STB_QUERY,
    RD_SERIAL_POLL,
    RD_SRM
  } read_sel_e;

  // Raw measurement conditions feeding the questionable register.
  typedef struct packed {
    logic volt_ovld;
    logic curr_ovld;
    logic ohms_ovld;
    logic limit_lo;
    logic limit_hi;
    logic remote;
  } meas_cond_s;

  // Host command strobes decoded by the parser.
  typedef struct packed {
    logic       clear_status;
    logic       ques_mask_wr;
    logic       srm_wr;
    logic [15:0] wdata;
    logic       rd_req;
    read_sel_e  rd_sel;
  } host_cmd_s;

endpackage

/* sticky_bit.sv */
`timescale 1ns/1ps
// One sticky flag: set wins over clear.
module sticky_bit (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Control.
  input  wire logic set_i,
  input  wire logic clr_i,
  // State.
  output logic      q_o
);

  // Holds the flag; a set in the clearing cycle survives.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end

endmodule
